// ### include/rx_protect_pkg.sv
package rx_protect_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int HOLD_TIME_NS = 20000;
    // A least time rounds up to whole cycles.
    localparam int HOLD_CYCLES =
        (HOLD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_W = 16;

    // ****************************************************************
    // Diode current check
    // ****************************************************************
    localparam int DIODE_COUNT = 8;
    localparam int OPEN_DIODE_LIMIT = 1;

    // ****************************************************************
    // Switch states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RECEIVE = 2'b00,
        ST_PROTECT = 2'b01,
        ST_HOLD = 2'b10
    } switch_state_t;

endpackage

// ### rtl/sync2.sv
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk, // Clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] async_in, // Inputs from another domain.
    output logic [WIDTH-1:0] sync_out // Synchronised copies.
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // sync2

`default_nettype wire

// ### rtl/rx_protect_switch.sv
`timescale 1ns/10ps
`default_nettype none

module rx_protect_switch
    import rx_protect_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES,
    parameter int NUM_DIODES = DIODE_COUNT
) (
    input wire logic sys_clk, // 250 MHz clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic request_optical, // Protect request, fibre input.
    input wire logic request_alt, // Protect request, electrical input.
    input wire logic [NUM_DIODES-1:0] diode_ok, // Per-diode current good.
    input wire logic chain_ack, // Acknowledge from chained unit.
    input wire logic primary_mode, // High on first unit of a chain.
    input wire logic chain_present, // High when a unit is chained behind.
    output logic protect_drive, // High shorts the receiver input.
    output logic request_out, // Repeated request, primary.
    output logic request_out_alt, // Repeated request, alternate.
    output logic ack_out, // Acknowledge to transmitter, primary.
    output logic ack_out_alt, // Acknowledge to transmitter, alternate.
    output switch_state_t state // Current switch state.
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SW = NUM_DIODES + 3;

    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync_in;

    assign raw_in = {diode_ok, chain_ack, request_alt, request_optical};

    sync2 #(.WIDTH(SW)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    // Either request path counts; the requester keeps the other idle.
    wire req_live = sync_in[0] | sync_in[1];
    wire chain_ack_s = sync_in[2];
    wire [NUM_DIODES-1:0] diode_s = sync_in[SW-1:3];

    // ****************************************************************
    // Diode current check
    // ****************************************************************
    function automatic int count_open(input logic [NUM_DIODES-1:0] ok);
        int n;
        n = 0;
        for (int i = 0; i < NUM_DIODES; i++) begin
            if (!ok[i]) begin
                n++;
            end
        end
        return n;
    endfunction

    // Sum of per-diode sense stands in for the total current check.
    wire current_ok = count_open(diode_s) <= OPEN_DIODE_LIMIT;

    // ****************************************************************
    // Switch state and hold one-shot
    // ****************************************************************
    logic [HOLD_W-1:0] hold_cnt;
    logic [HOLD_W-1:0] next_hold_cnt;
    switch_state_t next_state;

    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_COUNT - 1);

    always_comb begin
        next_state = state;
        next_hold_cnt = hold_cnt;
        unique case (state)
            ST_RECEIVE: begin
                if (req_live) begin
                    next_state = ST_PROTECT;
                end
            end
            ST_PROTECT: begin
                if (!req_live) begin
                    next_state = ST_HOLD;
                    next_hold_cnt = HOLD_LOAD;
                end
            end
            ST_HOLD: begin
                if (req_live) begin
                    next_state = ST_PROTECT;
                end else if (hold_cnt == '0) begin
                    next_state = ST_RECEIVE;
                end else begin
                    next_hold_cnt = hold_cnt - 1'b1;
                end
            end
            default: begin
                next_state = ST_PROTECT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_RECEIVE;
            hold_cnt <= '0;
        end else begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    wire protecting = (state != ST_RECEIVE);
    // Only the first unit waits on a chained partner; a lone unit does not.
    wire chain_term = chain_ack_s | !chain_present | !primary_mode;
    // Acknowledge drops with the request, long before the hold ends.
    wire next_ack = current_ok & req_live & protecting
                    & chain_term;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            protect_drive <= 1'b0;
            request_out <= 1'b0;
            request_out_alt <= 1'b0;
            ack_out <= 1'b0;
            ack_out_alt <= 1'b0;
        end else begin
            protect_drive <= (next_state != ST_RECEIVE);
            request_out <= req_live;
            request_out_alt <= req_live;
            ack_out <= next_ack;
            ack_out_alt <= next_ack;
        end
    end

endmodule // rx_protect_switch

`default_nettype wire

// ### test/rx_protect_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// Checker
// ********
module rx_protect_monitor import rx_protect_pkg::*; #(
    parameter int HOLD_COUNT = 8,
    parameter int NUM_DIODES = 8
) (
    input wire logic sys_clk, rst_n, request_optical, request_alt, chain_ack,
    input wire logic primary_mode, chain_present, protect_drive, request_out,
    input wire logic request_out_alt, ack_out, ack_out_alt,
    input wire logic [NUM_DIODES-1:0] diode_ok,
    input wire switch_state_t state
);
    localparam int HMAX = HOLD_COUNT + 6;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_req_copy: assert property (request_out == request_out_alt)
        else $error("request copies differ");
    chk_ack_copy: assert property (ack_out == ack_out_alt)
        else $error("acknowledge copies differ");
    chk_ack_protect: assert property (ack_out |-> protect_drive)
        else $error("acknowledge without protection");
    chk_req_rise: assert property ($rose(request_optical | request_alt)
        |-> ##[1:4] request_out && protect_drive)
        else $error("request not taken");
    chk_ack_drop: assert property ($fell(request_optical | request_alt)
        |-> ##[1:4] !ack_out)
        else $error("acknowledge outlived request");
    chk_hold_time: assert property ($fell(request_out) |-> protect_drive [*6]
        ##[1:HMAX] !protect_drive)
        else $error("hold extension wrong");
    chk_open_diodes: assert property ($countones(diode_ok) < NUM_DIODES - 1
        [*5] |-> !ack_out)
        else $error("acknowledge with two open diodes");
    chk_chain_and: assert property (primary_mode && chain_present
        && !chain_ack [*5] |-> !ack_out)
        else $error("chained acknowledge ignored");
    chk_state_drive: assert property (protect_drive
        == (state != ST_RECEIVE))
        else $error("state and drive disagree");
endmodule // rx_protect_monitor
bind rx_protect_switch rx_protect_monitor #(.HOLD_COUNT(HOLD_COUNT),
    .NUM_DIODES(NUM_DIODES)) rx_protect_monitor_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .request_optical(request_optical),
    .request_alt(request_alt), .chain_ack(chain_ack),
    .primary_mode(primary_mode), .chain_present(chain_present),
    .protect_drive(protect_drive), .request_out(request_out),
    .request_out_alt(request_out_alt), .ack_out(ack_out),
    .ack_out_alt(ack_out_alt), .diode_ok(diode_ok), .state(state));
`default_nettype wire

// ### test/tx_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// Transmitter controller
// ********
module tx_ctrl_model (
    input wire logic sys_clk, // Clock.
    input wire logic cmd, // Protect wanted.
    input wire logic use_alt, // Use the electrical input.
    input wire logic ack, // Acknowledge back.
    output logic request_optical, // Fibre request.
    output logic request_alt, // Electrical request.
    output logic tx_pulse // Pulse allowed.
);
    always_ff @(posedge sys_clk) begin
        request_optical <= cmd && !use_alt;
        request_alt <= cmd && use_alt;
        tx_pulse <= cmd && ack;
    end
endmodule // tx_ctrl_model
`default_nettype wire

// ### test/receiver_protect_switch_logic_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// Bench
// ********
module receiver_protect_switch_logic_tb_top import rx_protect_pkg::*;;
    logic sys_clk, rst_n, cmd, use_alt, chain_ack, primary_mode, chain_present;
    logic ro, ra, pd, rq, rqa, ak, aka, txp;
    logic [7:0] diode_ok;
    switch_state_t state;
    int fail_count, compares;
    tx_ctrl_model tx_ctrl_model_inst (.sys_clk(sys_clk), .cmd(cmd),
        .use_alt(use_alt), .ack(ak), .request_optical(ro),
        .request_alt(ra), .tx_pulse(txp));
    rx_protect_switch #(.HOLD_COUNT(8)) rx_protect_switch_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .request_optical(ro),
        .request_alt(ra), .diode_ok(diode_ok), .chain_ack(chain_ack),
        .primary_mode(primary_mode), .chain_present(chain_present),
        .protect_drive(pd), .request_out(rq), .request_out_alt(rqa),
        .ack_out(ak), .ack_out_alt(aka), .state(state));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic c, a, input logic [7:0] d, input logic p, k);
        @(posedge sys_clk);
        cmd <= c;
        use_alt <= a;
        diode_ok <= d;
        chain_present <= p;
        chain_ack <= k;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_request();
        go(1'b1, 1'b0, 8'hFF, 1'b0, 1'b0);
        check({rq, rqa, ak, aka, txp, pd}, 8'h3F);
        check(state, ST_PROTECT);
        go(1'b0, 1'b0, 8'hFF, 1'b0, 1'b0);
        check({rq, ak, aka, pd}, 8'h01);
        repeat (12) @(posedge sys_clk);
        #1;
        check({pd, state}, {1'b0, ST_RECEIVE});
        $display("test request done");
    endtask
    task automatic t_alt_diodes();
        go(1'b1, 1'b1, 8'hFE, 1'b0, 1'b0);
        check({rq, ak}, 8'h03);
        go(1'b1, 1'b0, 8'hFC, 1'b0, 1'b0);
        check({ak, aka, txp, pd}, 8'h01);
        $display("test diodes done");
    endtask
    task automatic t_chain();
        go(1'b1, 1'b0, 8'hFF, 1'b1, 1'b0);
        check(ak, 8'h00);
        go(1'b1, 1'b0, 8'hFF, 1'b1, 1'b1);
        check(ak, 8'h01);
        go(1'b1, 1'b0, 8'hFF, 1'b0, 1'b0);
        check(ak, 8'h01);
        @(posedge sys_clk);
        primary_mode <= 1'b0;
        go(1'b1, 1'b0, 8'hFF, 1'b1, 1'b0);
        check(ak, 8'h01);
        primary_mode <= 1'b1;
        $display("test chain done");
    endtask
    task automatic summarize();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
    initial begin
        {rst_n, cmd, use_alt, chain_ack, chain_present} = 5'h00;
        primary_mode = 1;
        diode_ok = 8'hFF;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1;
        t_request();
        t_alt_diodes();
        t_chain();
        summarize();
    end
endmodule // receiver_protect_switch_logic_tb_top
`default_nettype wire
